// file: verilog/tma_timer.sv
// Five channel down-counting timer with APB registers
`timescale 1ns/10ps
`default_nettype none

module tma_timer
    import tma_pkg::*;
#(
    parameter int NCH = TMA_NCH,   // Channels
    parameter int CW  = TMA_CW     // Counter width
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [TMA_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NCH-1:0]    channel_input_pin,
    input  wire logic              slow_osc_clk,
    input  wire logic              subclock_div32,
    output logic      [NCH-1:0]    channel_output_pin,
    output logic      [NCH-1:0]    channel_output_oe,
    output logic                   irq
);

    // Pin synchroniser width: gates plus two clock pins
    localparam int SW = NCH + 2;

    // Register file
    tma_mode_s           mode_reg [NCH];   // Channel mode registers
    logic [CW-1:0]       reload_reg [NCH]; // Reload values
    logic [CW-1:0]       cnt_reg [NCH];    // Live counters
    logic [NCH-1:0]      start_reg;        // Run bits
    logic [NCH*TMA_EXT_W-1:0] ext_reg;     // Source extension
    logic [NCH-1:0]      pol_reg;          // Output inversion
    logic [NCH-1:0]      sts_reg;          // Sticky interrupt flags
    logic [NCH-1:0]      en_reg;           // Interrupt enables
    logic [NCH-1:0]      out_reg;          // Pulse output state
    logic [NCH-1:0]      done_reg;         // One-shot finished
    logic [5:0]          pre_reg;          // Prescaler
    logic [31:0]         rdata_next;       // Read mux
    logic                err_next;         // Unmapped address

    // Synchroniser stages and filtered levels
    logic [SW-1:0]       sync1_reg;
    logic [SW-1:0]       sync2_reg;
    logic [SW-1:0]       sync3_reg;
    logic [SW-1:0]       filt_reg;
    logic [SW-1:0]       rise;             // Filtered rising edges

    // Per-channel and APB phase strobes
    logic [NCH-1:0]      cnt_wr;           // Count register write
    logic [NCH-1:0]      uf;               // Underflow event
    logic                wr_acc;           // Write access phase
    logic                setup;            // Setup phase

    // Index match on word address
    function automatic logic hit(input logic [TMA_AW-1:0] a,
                                 input logic [9:0] idx);
        hit = (a[TMA_AW-1:2] == idx);
    endfunction

    // Prescaler tap for a divide code
    function automatic logic src_tick(input logic [1:0] sel,
                                      input logic [TMA_EXT_W-1:0] ext,
                                      input logic [5:0] pre,
                                      input logic osc,
                                      input logic sub);
        src_tick = 1'b0;
        if (ext[TMA_EXT_ENB]) begin
            // Extension takes over the mode bits
            if (ext[1:0] == TMA_EXT_OSC) begin
                src_tick = osc;
            end else if (ext[1:0] == TMA_EXT_SUB) begin
                src_tick = sub;
            end else begin
                src_tick = pre[0];
            end
        end else if (sel == TMA_SRC_D1) begin
            src_tick = 1'b1;
        end else if (sel == TMA_SRC_D8) begin
            src_tick = &pre[2:0];
        end else if (sel == TMA_SRC_D32) begin
            src_tick = &pre[4:0];
        end else begin
            src_tick = &pre;
        end
    endfunction

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    // Read data is staged in setup, so no wait states
    assign pready = 1'b1;

    // Three-stage pin synchroniser; change counts when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg  <= '0;
        end else begin
            sync1_reg <= {subclock_div32, slow_osc_clk, channel_input_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int k = 0; k < SW; k++) begin
                if (sync2_reg[k] == sync3_reg[k]) begin
                    filt_reg[k] <= sync3_reg[k];
                end
            end
        end
    end

    // Edge once stable value moves high
    assign rise = sync2_reg & sync3_reg & ~filt_reg;

    // Free-running prescaler for divided enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    // Shared registers written from APB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg <= '0;
            ext_reg   <= '0;
            pol_reg   <= '0;
            en_reg    <= '0;
        end else if (wr_acc) begin
            if (hit(paddr, TMA_IDX_START)) begin
                start_reg <= pwdata[NCH-1:0];
            end else if (hit(paddr, TMA_IDX_EXT)) begin
                ext_reg <= pwdata[NCH*TMA_EXT_W-1:0];
            end else if (hit(paddr, TMA_IDX_POL)) begin
                pol_reg <= pwdata[NCH-1:0];
            end else if (hit(paddr, TMA_IDX_EN)) begin
                en_reg <= pwdata[NCH-1:0];
            end
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_reg <= '0;
        end else if (wr_acc && hit(paddr, TMA_IDX_CLR)) begin
            sts_reg <= (sts_reg & ~pwdata[NCH-1:0]) | uf;
        end else begin
            sts_reg <= sts_reg | uf;
        end
    end

    assign irq = |(sts_reg & en_reg);

    // Identical channels; loop keeps them the same
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        tma_mode_e     md;        // Operating mode
        logic          act;       // Qualified running
        logic          src;       // Selected count source
        logic          tick;      // Count enable this cycle
        logic          zero_val;  // Counter held idle
        logic          at_min;    // Counter at zero

        assign md  = mode_reg[i].op_mode;
        assign src = src_tick(mode_reg[i].count_src_sel,
                              ext_reg[i*TMA_EXT_W +: TMA_EXT_W],
                              pre_reg, rise[NCH], rise[NCH+1]);
        // Zero reload idles counter; 8-bit PWM also idles on zero high byte
        assign zero_val = (reload_reg[i] == '0)
            || (md == TMA_PWM && mode_reg[i].gate_lvl
                && reload_reg[i][CW-1:CW-8] == 8'h00);
        // Gate compares stable pin level with chosen active level
        assign act = start_reg[i] && !zero_val && !done_reg[i]
            && (!mode_reg[i].gate_en || md == TMA_EVENT
                || filt_reg[i] == mode_reg[i].gate_lvl);
        // Event mode counts pin edges, others the internal source
        assign tick = act && ((md == TMA_EVENT) ? rise[i] : src);
        assign at_min = (cnt_reg[i] == '0);
        assign uf[i] = tick && at_min;

        // Mode register write
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode_reg[i] <= tma_mode_s'(TMA_MODE_RST);
            end else if (wr_acc && hit(paddr, TMA_IDX_MODE + 10'(i))) begin
                mode_reg[i] <= tma_mode_s'(pwdata[7:0]);
            end
        end

        assign cnt_wr[i] = wr_acc && hit(paddr, TMA_IDX_COUNT + 10'(i));

        // Reload register always takes a count write
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                reload_reg[i] <= '0;
            end else if (cnt_wr[i]) begin
                reload_reg[i] <= pwdata[CW-1:0];
            end
        end

        // Down counter with reload on underflow
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg[i] <= '0;
            end else if (cnt_wr[i] && !start_reg[i]) begin
                cnt_reg[i] <= pwdata[CW-1:0];
            end else if (tick) begin
                if (at_min) begin
                    // One-shot stays at zero; others reload
                    if (md != TMA_ONESHOT) begin
                        cnt_reg[i] <= reload_reg[i];
                    end
                end else begin
                    cnt_reg[i] <= cnt_reg[i] - 1'b1;
                end
            end
        end

        // One-shot finish flag, cleared by stopping
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                done_reg[i] <= 1'b0;
            end else if (!start_reg[i] || md != TMA_ONESHOT) begin
                done_reg[i] <= 1'b0;
            end else if (uf[i]) begin
                done_reg[i] <= 1'b1;
            end
        end

        // Output state; held low while stopped so polarity sets rest level
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_reg[i] <= 1'b0;
            end else if (!start_reg[i] || zero_val) begin
                out_reg[i] <= 1'b0;
            end else if (md == TMA_ONESHOT) begin
                out_reg[i] <= act && !uf[i];
            end else if (uf[i]) begin
                out_reg[i] <= ~out_reg[i];
            end
        end

        // Pin driven only when pulse output enabled
        assign channel_output_oe[i]  = mode_reg[i].mode_specific_bit0;
        assign channel_output_pin[i] = mode_reg[i].mode_specific_bit0
            & (out_reg[i] ^ pol_reg[i]);
    end

    // Read mux; clear register reads zero
    always_comb begin
        rdata_next = '0;
        err_next   = 1'b0;
        if (paddr[TMA_AW-1:2] >= TMA_IDX_MODE
            && paddr[TMA_AW-1:2] < TMA_IDX_MODE + 10'(NCH)) begin
            rdata_next[7:0] = mode_reg[paddr[4:2] - 3'h6];
        end else if (paddr[TMA_AW-1:2] >= TMA_IDX_COUNT
            && paddr[TMA_AW-1:2] < TMA_IDX_COUNT + 10'(NCH)) begin
            rdata_next[CW-1:0] = cnt_reg[paddr[4:2]];
        end else if (hit(paddr, TMA_IDX_START)) begin
            rdata_next[NCH-1:0] = start_reg;
        end else if (hit(paddr, TMA_IDX_EXT)) begin
            rdata_next[NCH*TMA_EXT_W-1:0] = ext_reg;
        end else if (hit(paddr, TMA_IDX_POL)) begin
            rdata_next[NCH-1:0] = pol_reg;
        end else if (hit(paddr, TMA_IDX_STS)) begin
            rdata_next[NCH-1:0] = sts_reg;
        end else if (hit(paddr, TMA_IDX_EN)) begin
            rdata_next[NCH-1:0] = en_reg;
        end else if (!hit(paddr, TMA_IDX_CLR)) begin
            err_next = 1'b1;
        end
    end

    // Read data and error captured in setup, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr <= err_next;
        end
    end

endmodule

`default_nettype wire

// file: verilog/tma_pkg.sv
// Constants and types for the five channel timer A block
//Function
//- Five independent 16-bit channels with own registers
//- Two-bit mode field; zero selects timer mode
//- All channels identical outside event counting
//- Seven internal count sources in timer mode
//- Mode source bits valid only when extension clear
//- Count down, reload on underflow, keep going
//- Reload n divides count source by n+1
//- Run bit starts and stops counting
//- Interrupt request on every underflow
//- Count register read returns live counter
//- Stopped write loads both; running, reload only
//- Gate pin level starts and stops counting
//- Pulse output toggles on underflow, low when stopped
//- Polarity inversion makes stopped level high
//- Zero count value stops counter, pulses, interrupts
//- PWM zero value holds output low, no interrupts
//- One-shot gives single pulse ending at zero
package tma_pkg;

    localparam int TMA_NCH = 5;             // Channel count
    localparam int TMA_CW  = 16;            // Counter width
    localparam int TMA_AW  = 12;            // APB address width

    // Register indexes; byte address is four times the index
    localparam logic [9:0] TMA_IDX_MODE  = 10'h336;  // Mode, one per channel
    localparam logic [9:0] TMA_IDX_COUNT = 10'h340;  // Count, one per channel
    localparam logic [9:0] TMA_IDX_START = 10'h345;  // Run bits
    localparam logic [9:0] TMA_IDX_EXT   = 10'h346;  // Source extension
    localparam logic [9:0] TMA_IDX_POL   = 10'h347;  // Output polarity
    localparam logic [9:0] TMA_IDX_STS   = 10'h348;  // Interrupt status
    localparam logic [9:0] TMA_IDX_EN    = 10'h349;  // Interrupt enable
    localparam logic [9:0] TMA_IDX_CLR   = 10'h34a;  // Interrupt clear

    localparam logic [7:0] TMA_MODE_RST = 8'h00;     // Mode reset value
    localparam int TMA_EXT_W   = 4;                  // Extension nibble per channel
    localparam int TMA_EXT_ENB = 3;                  // Extension enable bit in nibble

    // Operating modes
    typedef enum logic [1:0] {
        TMA_TIMER   = 2'b00,
        TMA_EVENT   = 2'b01,
        TMA_ONESHOT = 2'b10,
        TMA_PWM     = 2'b11
    } tma_mode_e;

    // Count source codes from the mode register
    localparam logic [1:0] TMA_SRC_D1  = 2'b00;
    localparam logic [1:0] TMA_SRC_D8  = 2'b01;
    localparam logic [1:0] TMA_SRC_D32 = 2'b10;
    localparam logic [1:0] TMA_SRC_D64 = 2'b11;
    // Extension codes
    localparam logic [1:0] TMA_EXT_D2  = 2'b00;
    localparam logic [1:0] TMA_EXT_OSC = 2'b01;
    localparam logic [1:0] TMA_EXT_SUB = 2'b10;

    // Channel mode register layout
    typedef struct packed {
        logic [1:0] count_src_sel;     // Bits 7:6
        logic       rsvd;              // Bit 5
        logic       gate_en;           // Bit 4
        logic       gate_lvl;          // Bit 3, also 8-bit PWM select
        logic       mode_specific_bit0; // Bit 2, pulse output enable
        tma_mode_e  op_mode;           // Bits 1:0
    } tma_mode_s;

endpackage

// file: verification/tma_properties.sv
// Port-level assertions for the five channel timer block
`timescale 1ns/10ps
`default_nettype none

module tma_properties
    import tma_pkg::*;
#(
    parameter int NCH = TMA_NCH    // Channels
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [TMA_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [NCH-1:0]    channel_output_pin,
    input wire logic [NCH-1:0]    channel_output_oe,
    input wire logic              irq
);
    logic [9:0] idx;       // Word index of the current transfer
    logic       mapped;    // Index falls in one of the two register windows
    assign idx    = paddr[11:2];
    assign mapped = (idx >= TMA_IDX_MODE && idx <= TMA_IDX_MODE + 10'h4)
                 || (idx >= TMA_IDX_COUNT && idx <= TMA_IDX_CLR);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_high: assert property (pready) else $error("pready dropped");
    a_slverr_bad: assert property (
        psel && !penable && !mapped |=> pslverr) else $error("no error on hole");
    a_slverr_ok: assert property (
        psel && !penable && mapped |=> !pslverr) else $error("error on register");
    a_write_zero: assert property (
        psel && !penable && pwrite |=> prdata == 32'h0) else $error("write data leak");
    a_read_stands: assert property (
        !(psel && !penable) |=> $stable(prdata) && $stable(pslverr)) else $error("read moved");
    a_pin_noe_low: assert property (
        (channel_output_pin & ~channel_output_oe) == '0) else $error("pin not low");
    a_oe_follow: assert property (
        psel && penable && pwrite && idx == TMA_IDX_MODE
        |=> channel_output_oe[0] == $past(pwdata[2])) else $error("oe mismatch");
    a_irq_masked: assert property (
        psel && penable && pwrite && idx == TMA_IDX_EN && pwdata[4:0] == 5'h0
        |-> ##2 !irq) else $error("irq while masked");

    c_irq_seen: cover property (irq);
    c_err_seen: cover property (psel && penable && pslverr);
    c_pin_rise: cover property ($rose(channel_output_pin[0]));
endmodule

bind tma_timer tma_properties #(.NCH(NCH)) tma_properties_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .channel_output_pin, .channel_output_oe, .irq);

`default_nettype wire

// file: verification/tma_pins.sv
// Far-side pin model: gate levels and the two slow external clocks
`timescale 1ns/10ps
`default_nettype none

module tma_pins
    import tma_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic [TMA_NCH-1:0] gate_cmd,
    output logic      [TMA_NCH-1:0] channel_input_pin,
    output logic                    slow_osc_clk,
    output logic                    subclock_div32
);
    logic [7:0] tick;    // Free count; slow clocks stay far below pclk so no edge is lost

    initial begin
        tick = 8'h00;
        channel_input_pin = '0;
        slow_osc_clk = 1'b0;
        subclock_div32 = 1'b0;
    end

    // Gate pins follow the commanded level; clocks divide the free count
    always @(posedge pclk) begin
        tick <= tick + 8'h01;
        channel_input_pin <= gate_cmd;
        slow_osc_clk <= tick[3];
        subclock_div32 <= tick[4];
    end
endmodule

`default_nettype wire

// file: verification/tb_timer_a_interval_mode.sv
// Self-checking bench for the five channel timer block
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end

module tb_timer_a_interval_mode import tma_pkg::*;;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [TMA_AW-1:0] paddr;
    logic [31:0]       pwdata, prdata, r;
    logic [4:0]        pin, oe, gate_cmd, gate_pin;
    logic              slow, sub;
    int                err_count, checks_done, c, n;
    int                mult[7] = '{1, 8, 32, 64, 2, 16, 32};  // Ticks per source
    logic [7:0]        md[7] = '{8'h04, 8'h44, 8'h84, 8'hc4, 8'hc4, 8'hc4, 8'hc4};
    logic [3:0]        ex[7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h9, 4'ha};

    tma_timer #(.NCH(5)) tma_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .channel_input_pin(gate_pin),
        .slow_osc_clk(slow), .subclock_div32(sub), .channel_output_pin(pin),
        .channel_output_oe(oe), .irq);
    tma_pins tma_pins_inst (.pclk, .gate_cmd, .channel_input_pin(gate_pin),
        .slow_osc_clk(slow), .subclock_div32(sub));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // One whole-word transfer; result left in r and e
    task automatic apb(input logic wr, input int ix, input logic [31:0] wd);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= 12'(ix * 4); pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Cycles between two pin toggles; the first toggle may be a partial period
    task automatic period(input int ch, input int expc);
        int k;
        logic p;
        for (int s = 0; s < 2; s++) begin
            p = pin[ch];
            k = 0;
            while (pin[ch] === p && k < 2000) begin @(posedge pclk); k++; end
        end
        `CHK("period", expc, k)
    endtask

    task automatic finish_test();
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        err_count++;
        finish_test();
    end

    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = '0; pwdata = '0; gate_cmd = '0;
        void'($urandom(32'h193b2be6));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (c = 0; c < 5; c++) begin
            apb(0, TMA_IDX_MODE + c, 0);
            `CHK("mode_rst", TMA_MODE_RST, r[7:0])
        end
        apb(0, 10'h3ff, 0);
        `CHK("unmapped", 1'b1, e)
        apb(1, TMA_IDX_COUNT + 4, 32'h1ffff);
        apb(0, TMA_IDX_COUNT + 4, 0);
        `CHK("count_width", 32'hffff, r)
        apb(1, TMA_IDX_EN, 32'h1f);
        for (c = 0; c < 5; c++) begin
            n = 2 + $urandom % 8;
            apb(1, TMA_IDX_COUNT + c, n);
            apb(0, TMA_IDX_COUNT + c, 0);
            `CHK("count_stopped", n, r)
            apb(1, TMA_IDX_MODE + c, 32'h04);
            apb(1, TMA_IDX_START, 1 << c);
            period(c, n + 1);
            apb(0, TMA_IDX_STS, 0);
            `CHK("sts_set", 1'b1, r[c])
            `CHK("irq_on", 1'b1, irq)
            apb(0, TMA_IDX_COUNT + c, 0);
            `CHK("live", 1'b1, r <= n)
            apb(1, TMA_IDX_COUNT + c, n + 3);
            period(c, n + 4);
            apb(1, TMA_IDX_START, 0);
            repeat (2) @(posedge pclk);
            `CHK("stop_low", 1'b0, pin[c])
            apb(1, TMA_IDX_POL, 1 << c);
            repeat (2) @(posedge pclk);
            `CHK("stop_high", 1'b1, pin[c])
            apb(1, TMA_IDX_POL, 0);
        end
        apb(1, TMA_IDX_EN, 0);
        `CHK("irq_mask", 1'b0, irq)
        apb(1, TMA_IDX_EN, 32'h1f);
        `CHK("irq_unmask", 1'b1, irq)
        apb(1, TMA_IDX_CLR, 32'h1f);
        apb(0, TMA_IDX_STS, 0);
        `CHK("sts_clr", 32'h0, r)
        `CHK("irq_clr", 1'b0, irq)
        apb(1, TMA_IDX_COUNT, 0);
        apb(1, TMA_IDX_MODE, 32'h04);
        apb(1, TMA_IDX_START, 32'h1);
        repeat (40) @(posedge pclk);
        apb(0, TMA_IDX_STS, 0);
        `CHK("zero_sts", 1'b0, r[0])
        `CHK("zero_pin", 1'b0, pin[0])
        apb(1, TMA_IDX_COUNT + 1, 5);
        apb(1, TMA_IDX_MODE + 1, 32'h1c);
        apb(1, TMA_IDX_START, 32'h2);
        repeat (20) @(posedge pclk);
        apb(0, TMA_IDX_COUNT + 1, 0);
        `CHK("gate_hold", 32'h5, r)
        gate_cmd <= 5'h02;
        period(1, 6);
        apb(1, TMA_IDX_COUNT + 2, 1);
        for (c = 0; c < 7; c++) begin
            apb(1, TMA_IDX_EXT, {20'h0, ex[c], 8'h0});
            apb(1, TMA_IDX_MODE + 2, {24'h0, md[c]});
            apb(1, TMA_IDX_START, 32'h4);
            period(2, 2 * mult[c]);
        end
        // Event mode: two pin edges through reload 1 give one toggle
        apb(1, TMA_IDX_COUNT, 1);
        apb(1, TMA_IDX_MODE, 32'h05);
        apb(1, TMA_IDX_START, 32'h1);
        repeat (2) begin
            gate_cmd <= 5'h01;
            repeat (8) @(posedge pclk);
            gate_cmd <= 5'h00;
            repeat (8) @(posedge pclk);
        end
        `CHK("event_pin", 1'b1, pin[0])
        // One-shot: high while counting, low and parked at zero afterwards
        apb(1, TMA_IDX_COUNT + 3, 4);
        apb(1, TMA_IDX_MODE + 3, 32'h06);
        apb(1, TMA_IDX_START, 32'h8);
        @(posedge pclk);
        `CHK("os_high", 1'b1, pin[3])
        repeat (20) @(posedge pclk);
        `CHK("os_low", 1'b0, pin[3])
        apb(0, TMA_IDX_COUNT + 3, 0);
        `CHK("os_stay", 32'h0, r)
        apb(0, TMA_IDX_STS, 0);
        `CHK("os_sts", 1'b1, r[3])
        // 8-bit PWM with zero high byte stays idle
        apb(1, TMA_IDX_COUNT + 4, 32'hff);
        apb(1, TMA_IDX_MODE + 4, 32'h0f);
        apb(1, TMA_IDX_START, 32'h10);
        repeat (40) @(posedge pclk);
        apb(0, TMA_IDX_STS, 0);
        `CHK("pwm_sts", 1'b0, r[4])
        `CHK("pwm_pin", 1'b0, pin[4])
        finish_test();
    end
endmodule

`default_nettype wire
